// ===== src/adc_result_calibration_regs.sv
// result, peek, calibration and bias registers of the converter, on apb
//
// Summary of operation
// - The scan result register returns the last scan result and a read clears scan valid.
// - The single peek register returns the single result and changes no flag or request.
// - The scan peek register returns the scan result and changes no flag or request.
// - Scan gain trim is an unsigned 7-bit field at bits 30:24, nominally 0x3f.
// - Scan offset trim is a 7-bit field at bits 22:16, nominally zero.
// - Single gain trim is an unsigned 7-bit field at bits 14:8, nominally 0x3f.
// - Single offset trim is a 7-bit field at bits 6:0, nominally zero.
// - Reset loads every calibration field with the part's factory trim values.
// - Offset trims are signed two's complement, gain trims are unsigned.
// - A larger offset trim gives a smaller converted result.
// - The bias halving bit resets to one and the 4-bit bias current level resets to seven.
// - A read of the single result register clears single valid, unlike a peek read.
`default_nettype none
module adc_result_calibration_regs
	import adc_regs_pkg::*;
#(
	parameter logic [31:0] FACTORY_CAL = 32'h3f00_3f00
) (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// from converter core
	input  wire logic        single_done,
	input  wire logic [31:0] single_data,
	input  wire logic        scan_done,
	input  wire logic [31:0] scan_data,
	input  wire logic        scan_active,
	// to converter core
	output logic             single_result_valid,
	output logic             scan_result_valid,
	output logic             single_dma_req,
	output logic             scan_dma_req,
	output logic [6:0]       active_gain_trim,
	output logic signed [6:0] active_offset_trim,
	output logic [3:0]       comparator_bias_level,
	output logic             bias_halving,
	output logic [3:0]       bias_current_level,
	output logic             irq
);
	logic [31:0]      cal;
	logic [31:0]      bias;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic             access;
	logic             rd;
	logic             wr;
	logic [31:0]      next_rdata;
	logic             next_err;
	logic [IRQ_W-1:0] events;

	result_if single_ch ();
	result_if scan_ch ();

	// zero wait state slave: pready is high in every access phase
	assign access = psel && penable;
	assign rd     = access && !pwrite && ce;
	assign wr     = access && pwrite && ce;

	assign single_ch.load = single_done;
	assign single_ch.data = single_data;
	assign single_ch.take = rd && paddr == OFF_SINGLE_RESULT;
	assign scan_ch.load   = scan_done;
	assign scan_ch.data   = scan_data;
	assign scan_ch.take   = rd && paddr == OFF_SCAN_RESULT;

	result_slice u_single (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.ch      (single_ch)
	);

	result_slice u_scan (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.ch      (scan_ch)
	);

	// the signed offset is handed to the core, which subtracts it
	trim_select u_trim (
		.pclk        (pclk),
		.presetn     (presetn),
		.ce          (ce),
		.scan_active (scan_active),
		.cal         (cal),
		.gain_trim   (active_gain_trim),
		.offset_trim (active_offset_trim)
	);

	// factory trim is a parameter, so the async reset still loads a constant and
	// the very first read after release already shows the part's own values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal <= FACTORY_CAL & CAL_MASK;
		end else if (ce && wr && paddr == OFF_CAL) begin
			cal <= pwdata & CAL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias <= 32'h0000_0747;
		end else if (ce && wr && paddr == OFF_BIAS) begin
			bias <= pwdata & BIAS_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_bias_level <= BIAS_NOMINAL;
			bias_halving          <= 1'b1;
			bias_current_level    <= BIAS_NOMINAL;
		end else if (ce) begin
			comparator_bias_level <= bias[COMP_BIAS_LSB +: 4];
			bias_halving          <= bias[HALF_BIAS_BIT];
			bias_current_level    <= bias[BIAS_LEVEL_LSB +: 4];
		end
	end

	// interrupt: sticky status, set wins over a write-one clear
	always_comb begin
		events                = '0;
		events[IRQ_SINGLE]    = single_done;
		events[IRQ_SCAN]      = scan_done;
		events[IRQ_SINGLE_OF] = single_ch.overflow;
		events[IRQ_SCAN_OF]   = scan_ch.overflow;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else if (ce) begin
			if (wr && paddr == OFF_IRQ_STATUS) begin
				irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | events;
			end else begin
				irq_status <= irq_status | events;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= '0;
		end else if (wr && paddr == OFF_IRQ_MASK) begin
			irq_mask <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(irq_status & irq_mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			single_result_valid <= 1'b0;
			scan_result_valid   <= 1'b0;
			single_dma_req      <= 1'b0;
			scan_dma_req        <= 1'b0;
		end else if (ce) begin
			single_result_valid <= single_ch.valid;
			scan_result_valid   <= scan_ch.valid;
			single_dma_req      <= single_ch.dma_req;
			scan_dma_req        <= scan_ch.dma_req;
		end
	end

	// read mux; peek reads have no side effect at all
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		unique case (paddr)
			OFF_SINGLE_RESULT: next_rdata = single_ch.value;
			OFF_SCAN_RESULT:   next_rdata = scan_ch.value;
			OFF_SINGLE_PEEK:   next_rdata = single_ch.value;
			OFF_SCAN_PEEK:     next_rdata = scan_ch.value;
			OFF_CAL:           next_rdata = cal;
			OFF_BIAS:          next_rdata = bias;
			OFF_IRQ_STATUS:    next_rdata = {28'h000_0000, irq_status};
			OFF_IRQ_MASK:      next_rdata = {28'h000_0000, irq_mask};
			OFF_CONV_STATUS:   next_rdata = {30'h0000_0000, scan_ch.valid, single_ch.valid};
			default:           next_err   = 1'b1;
		endcase
	end

	// prdata and pslverr are registered in the setup phase for the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
				pslverr <= next_err;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule : adc_result_calibration_regs
`default_nettype wire

// ===== include/adc_regs_pkg.sv
// register map, field layout and reset values of the converter result/calibration group
`default_nettype none
package adc_regs_pkg;
	localparam logic [7:0] OFF_SINGLE_RESULT = 8'h24;
	localparam logic [7:0] OFF_SCAN_RESULT   = 8'h28;
	localparam logic [7:0] OFF_SINGLE_PEEK   = 8'h2c;
	localparam logic [7:0] OFF_SCAN_PEEK     = 8'h30;
	localparam logic [7:0] OFF_CAL           = 8'h34;
	localparam logic [7:0] OFF_BIAS          = 8'h3c;
	localparam logic [7:0] OFF_IRQ_STATUS    = 8'h40;
	localparam logic [7:0] OFF_IRQ_MASK      = 8'h44;
	localparam logic [7:0] OFF_CONV_STATUS   = 8'h48;
	localparam int SCAN_GAIN_LSB     = 24;
	localparam int SCAN_OFFSET_LSB   = 16;
	localparam int SINGLE_GAIN_LSB   = 8;
	localparam int SINGLE_OFFSET_LSB = 0;
	localparam int TRIM_W            = 7;
	localparam int COMP_BIAS_LSB     = 8;
	localparam int HALF_BIAS_BIT     = 6;
	localparam int BIAS_LEVEL_LSB    = 0;
	localparam logic [6:0] GAIN_NOMINAL   = 7'h3f;
	localparam logic [6:0] OFFSET_NOMINAL = 7'h00;
	localparam logic [3:0] BIAS_NOMINAL   = 4'h7;
	localparam logic [31:0] CAL_MASK  = 32'h7f7f_7f7f;
	localparam logic [31:0] BIAS_MASK = 32'h0000_0f4f;
	// interrupt status and mask bits
	localparam int IRQ_SINGLE    = 0;
	localparam int IRQ_SCAN      = 1;
	localparam int IRQ_SINGLE_OF = 2;
	localparam int IRQ_SCAN_OF   = 3;
	localparam int IRQ_W         = 4;
endpackage : adc_regs_pkg
`default_nettype wire

// ===== include/result_if.sv
// one result channel between the register file and its holding slice
`default_nettype none
interface result_if;
	logic        load;
	logic [31:0] data;
	logic        take;
	logic [31:0] value;
	logic        valid;
	logic        dma_req;
	logic        overflow;
	modport slice (input load, data, take, output value, valid, dma_req, overflow);
	modport regs  (output load, data, take, input value, valid, dma_req, overflow);
endinterface : result_if
`default_nettype wire

// ===== src/result_slice.sv
// holds one conversion result with its data-valid flag and dma request
`default_nettype none
module result_slice (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// channel
	result_if.slice   ch
);
	// a new result in the same cycle as a destructive read keeps the flag set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch.value    <= 32'h0000_0000;
			ch.valid    <= 1'b0;
			ch.dma_req  <= 1'b0;
			ch.overflow <= 1'b0;
		end else if (ce) begin
			ch.overflow <= ch.load && ch.valid && !ch.take;
			if (ch.load) begin
				ch.value   <= ch.data;
				ch.valid   <= 1'b1;
				ch.dma_req <= 1'b1;
			end else if (ch.take) begin
				ch.valid   <= 1'b0;
				ch.dma_req <= 1'b0;
			end
		end
	end
endmodule : result_slice
`default_nettype wire

// ===== src/trim_select.sv
// picks the trim pair for the conversion type in progress
`default_nettype none
module trim_select
	import adc_regs_pkg::*;
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// selection
	input  wire logic              scan_active,
	input  wire logic [31:0]       cal,
	// outputs to core
	output logic [TRIM_W-1:0]      gain_trim,
	output logic signed [TRIM_W-1:0] offset_trim
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_trim   <= GAIN_NOMINAL;
			offset_trim <= OFFSET_NOMINAL;
		end else if (ce) begin
			if (scan_active) begin
				gain_trim   <= cal[SCAN_GAIN_LSB +: TRIM_W];
				offset_trim <= cal[SCAN_OFFSET_LSB +: TRIM_W];
			end else begin
				gain_trim   <= cal[SINGLE_GAIN_LSB +: TRIM_W];
				offset_trim <= cal[SINGLE_OFFSET_LSB +: TRIM_W];
			end
		end
	end
endmodule : trim_select
`default_nettype wire

// ===== sim/adc_regs_assertions.sv
// port assertions for the converter result and trim registers
`default_nettype none
module adc_regs_assertions
	import adc_regs_pkg::*;
#(
	parameter logic [31:0] FACTORY_CAL = 32'h3f00_3f00
) (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// core side
	input wire logic        single_done,
	input wire logic        scan_done,
	input wire logic        scan_active,
	input wire logic        single_result_valid,
	input wire logic        scan_result_valid,
	input wire logic        single_dma_req,
	input wire logic [6:0]  active_gain_trim,
	input wire logic signed [6:0] active_offset_trim,
	input wire logic [3:0]  comparator_bias_level,
	input wire logic        bias_halving,
	input wire logic [3:0]  bias_current_level
);
	wire         rd = psel && penable && ce && !pwrite;
	wire         wr = psel && penable && ce && pwrite;
	logic [31:0] cal_sh;
	logic        loaded;
	// shadow trim; until the first enabled edge the trim outputs still show nominal values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_sh <= FACTORY_CAL & CAL_MASK;
			loaded <= 1'b0;
		end else if (ce) begin
			loaded <= 1'b1;
			if (wr && paddr == OFF_CAL)
				cal_sh <= pwdata & CAL_MASK;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_lag2; ##2 1'b1; endsequence
	property p_ready; s_setup |=> pready; endproperty
	property p_scan_clr; rd && paddr == OFF_SCAN_RESULT && !scan_done |=> ##1 !scan_result_valid; endproperty
	property p_sgl_clr; rd && paddr == OFF_SINGLE_RESULT && !single_done |=> ##1 !single_result_valid; endproperty
	property p_scan_peek; rd && paddr == OFF_SCAN_PEEK && scan_result_valid |=> ##1 scan_result_valid; endproperty
	property p_sgl_peek; rd && paddr == OFF_SINGLE_PEEK && single_dma_req |=> ##1 single_dma_req; endproperty
	property p_dma_wd; rd && paddr == OFF_SINGLE_RESULT && !single_done |-> ##[1:2] !single_dma_req; endproperty
	property p_bias; wr && paddr == OFF_BIAS |-> s_lag2 ##0 {comparator_bias_level, bias_halving,
		bias_current_level} == {$past(pwdata[11:8], 2), $past(pwdata[6], 2), $past(pwdata[3:0], 2)}; endproperty
	// a frozen clock enable holds the trim outputs, so only enabled edges are judged
	property p_gain; $past(ce) |-> active_gain_trim == (loaded ? ($past(scan_active) ?
		$past(cal_sh[30:24]) : $past(cal_sh[14:8])) : GAIN_NOMINAL); endproperty
	property p_offs; $past(ce) |-> active_offset_trim == (loaded ? ($past(scan_active) ?
		$past(cal_sh[22:16]) : $past(cal_sh[6:0])) : OFFSET_NOMINAL); endproperty
	a_ready: assert property (p_ready) else $error("no pready in access");
	a_scan_clr: assert property (p_scan_clr) else $error("scan valid kept");
	a_sgl_clr: assert property (p_sgl_clr) else $error("single valid kept");
	a_scan_peek: assert property (p_scan_peek) else $error("scan peek cleared");
	a_sgl_peek: assert property (p_sgl_peek) else $error("single peek took dma");
	a_dma_wd: assert property (p_dma_wd) else $error("dma request kept");
	a_bias: assert property (p_bias) else $error("bias outputs wrong");
	a_gain: assert property (p_gain) else $error("gain trim wrong");
	a_offs: assert property (p_offs) else $error("offset trim wrong");
endmodule : adc_regs_assertions
bind adc_result_calibration_regs adc_regs_assertions #(.FACTORY_CAL(FACTORY_CAL)) u_chk (
	.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .single_done,
	.scan_done, .scan_active, .single_result_valid, .scan_result_valid, .single_dma_req,
	.active_gain_trim, .active_offset_trim, .comparator_bias_level, .bias_halving,
	.bias_current_level);
`default_nettype wire

// ===== sim/tb_adc_result_calibration_regs.sv
// self-checking bench for the converter result and trim registers
`default_nettype none
module tb_adc_result_calibration_regs import adc_regs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// part trim off the nominal so the reset load is visible
	localparam logic [31:0] FCAL = 32'h2a05_3b7e;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic        single_done, scan_done, scan_active, bias_halving;
	logic        single_result_valid, scan_result_valid, single_dma_req, scan_dma_req;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, single_data, scan_data, v;
	logic [6:0]  active_gain_trim;
	logic signed [6:0] active_offset_trim;
	logic [3:0]  comparator_bias_level, bias_current_level;
	logic [1:0]  vld, dma;
	logic [32:0] exp_q[$];
	int          n_mismatch = 0;
	int          tests_run = 0;
	integer      seed = 32'h957a_eeaa;
	assign vld = {scan_result_valid, single_result_valid};
	assign dma = {scan_dma_req, single_dma_req};
	adc_result_calibration_regs #(.FACTORY_CAL(FCAL)) DUT (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .single_done,
		.single_data, .scan_done, .scan_data, .scan_active, .single_result_valid,
		.scan_result_valid, .single_dma_req, .scan_dma_req, .active_gain_trim,
		.active_offset_trim, .comparator_bias_level, .bias_halving, .bias_current_level, .irq);
	task automatic check(input string nm, input logic [32:0] s, input logic [32:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	// one idle cycle after each transfer keeps the strobes single-driven per step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here: a missing pready is caught by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic conv(input int c);
		v = $random(seed);
		single_data <= v;
		scan_data <= v;
		single_done <= !c[0];
		scan_done <= c[0];
		tick(1);
		single_done <= 1'b0;
		scan_done <= 1'b0;
		tick(3);
	endtask : conv
	// read answers are compared in arrival order against the noted values
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1)
			check("apb", {pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		#20000;
		n_mismatch++;
		$display("ERROR watchdog expected end seen timeout");
		close_out();
	end
	initial begin
		{presetn, psel, penable, pwrite, single_done, scan_done, scan_active} = '0;
		{paddr, pwdata, single_data, scan_data} = '0;
		ce = 1'b1;
		tick(2);
		presetn <= 1'b1;
		check("bias", {comparator_bias_level, bias_halving, bias_current_level},
			9'h0f7);
		xfer(0, OFF_CAL, '0, {1'b0, FCAL});
		xfer(0, OFF_BIAS, '0, 33'h747);
		xfer(0, OFF_SCAN_PEEK, '0, '0);
		xfer(1, 8'h38, 32'hffff_ffff, {1'b1, 32'h0});
		xfer(0, 8'h38, '0, {1'b1, 32'h0});
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			v = $random(seed) & CAL_MASK;
			xfer(1, OFF_CAL, v, '0);
			xfer(0, OFF_CAL, '0, {1'b0, v});
			scan_active <= i[0];
			tick(3);
			check("gain", active_gain_trim, i[0] ? v[30:24] : v[14:8]);
			check("offs", $unsigned(active_offset_trim), i[0] ? v[22:16] : v[6:0]);
			v = $random(seed) & BIAS_MASK;
			xfer(1, OFF_BIAS, v, '0);
			xfer(0, OFF_BIAS, '0, {1'b0, v});
			check("bias", {comparator_bias_level, bias_halving, bias_current_level},
				{v[11:8], v[6], v[3:0]});
		end
		// a write while the clock enable is low must leave the register untouched
		ce <= 1'b0;
		xfer(1, OFF_BIAS, 32'h0000_0000, '0);
		ce <= 1'b1;
		xfer(0, OFF_BIAS, '0, {1'b0, v});
		$display("test registers done");
		for (int c = 0; c < 2; c++) begin
			conv(c);
			check("valid", vld[c], 1'b1);
			xfer(0, c ? OFF_SCAN_PEEK : OFF_SINGLE_PEEK, '0, {1'b0, v});
			tick(2);
			check("valid", vld[c], 1'b1);
			check("dma", dma[c], 1'b1);
			xfer(0, c ? OFF_SCAN_RESULT : OFF_SINGLE_RESULT, '0, {1'b0, v});
			tick(2);
			check("valid", vld[c], 1'b0);
			check("dma", dma[c], 1'b0);
		end
		$display("test results done");
		xfer(1, OFF_IRQ_STATUS, 32'h0000_000f, '0);
		xfer(1, OFF_IRQ_MASK, 32'h0000_0001, '0);
		check("irq", irq, 1'b0);
		conv(0);
		check("irq", irq, 1'b1);
		xfer(1, OFF_IRQ_MASK, '0, '0);
		tick(2);
		check("irq", irq, 1'b0);
		xfer(1, OFF_IRQ_STATUS, 32'h0000_0001, '0);
		conv(0);
		xfer(0, OFF_IRQ_STATUS, '0, 33'h5);
		xfer(0, OFF_CONV_STATUS, '0, 33'h1);
		xfer(1, OFF_IRQ_MASK, 32'h0000_0004, '0);
		tick(2);
		check("irq", irq, 1'b1);
		xfer(1, OFF_IRQ_STATUS, 32'h0000_0005, '0);
		tick(2);
		check("irq", irq, 1'b0);
		$display("test interrupt done");
		close_out();
	end
endmodule : tb_adc_result_calibration_regs
`default_nettype wire
